/* logic/i2cms_core.sv */
// Purpose: Master sequencer for a two-wire bus with an AXI4-Lite register port.
// Assumes: Open-drain pins; the bus levels are sampled through two flip-flops.
// Notes: Clock stretching and slave modes are not handled.
// Contract
// [R1] Acknowledge slot drives the acknowledge-value bit.
// [R2] Value one sends NACK, zero sends ACK.
// [R3] Acknowledge request launches acknowledge sequence.
// [R4] Acknowledge request self-clears when sequence ends.
// [R5] Receive request takes byte, clears after bit eight.
// [R6] Stop request makes Stop, then self-clears.
// [R7] Restart request makes Repeated Start, then self-clears.
// [R8] Start request makes Start on the pins.
// [R9] Start request self-clears at sequence end.
// [R10] Receive-full set on store, cleared on read.
// [R11] Collision flag set by hardware, cleared by software.
// [R12] Slave acknowledge flag updated each acknowledge slot.
module i2cms_core #(
  parameter int QUARTER = i2cms_pkg::QUARTER_CYCLES
) (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [7:0] awaddr, // Write address.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  output logic [1:0] bresp, // Write response code.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  input wire logic [7:0] araddr, // Read address.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response code.
  input wire logic serial_data_pin_in, // Data line level.
  output logic serial_data_pin_out, // Data line drive value, always low.
  output logic serial_data_pin_oe_n, // Low while pulling data line low.
  input wire logic serial_clock_pin_in, // Clock line level.
  output logic serial_clock_pin_out, // Clock line drive value, always low.
  output logic serial_clock_pin_oe_n, // Low while pulling clock line low.
  output logic irq // Level interrupt.
);
  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  i2cms_pkg::i2cms_ctrl_t ctrl; // Control register.
  i2cms_pkg::i2cms_state_t state; // Sequencer state.
  logic [15:0] qcnt; // Quarter period counter.
  logic [1:0] q; // Quarter within the bit.
  logic [3:0] bitcnt; // Bit within the byte.
  logic [7:0] txsh, rxsh; // Transmit and receive shifters.
  logic [7:0] transmit_buffer, receive_buffer; // Byte to send and last byte received.
  logic transmit_buffer_full, receive_buffer_full; // Byte pending to send, byte unread.
  logic slave_ack_flag, bus_collision_flag, hold_low; // Slave NACK, collision, clock held.
  logic [2:0] irq_stat, irq_mask; // Sticky interrupt status and its enables.
  logic sda_s1, sda_s2, scl_s1, scl_s2; // Pin synchronisers.
  logic [31:0] rd_mux; // Read data selection.
  logic next_sda_rel, next_scl_rel; // Wanted pin release levels.
  ////////////////////////////////////////////////////////////////////////////////
  // Decoding.
  wire wr_go = awvalid && wvalid && !bvalid; // Both write channels taken together.
  wire rd_go = arvalid && !rvalid; // Read address taken.
  wire [15:0] wmask = {{8{wstrb[1]}}, {8{wstrb[0]}}}; // Lane enables.
  wire [15:0] wd = wdata[15:0] & wmask; // Masked write data.
  wire wr_ctrl = wr_go && awaddr == i2cms_pkg::OFS_CTRL;
  wire wr_stat = wr_go && awaddr == i2cms_pkg::OFS_STAT;
  wire wr_txb = wr_go && awaddr == i2cms_pkg::OFS_TXB && wstrb[0];
  wire wr_imask = wr_go && awaddr == i2cms_pkg::OFS_IMASK;
  wire wr_istat = wr_go && awaddr == i2cms_pkg::OFS_ISTAT;
  wire rd_rxb = rd_go && araddr == i2cms_pkg::OFS_RXB;
  wire wr_hit = wr_ctrl || wr_stat || wr_txb || wr_imask || wr_istat ||
                (wr_go && awaddr == i2cms_pkg::OFS_RXB);
  wire rd_hit = araddr == i2cms_pkg::OFS_CTRL || araddr == i2cms_pkg::OFS_STAT ||
                araddr == i2cms_pkg::OFS_TXB || araddr == i2cms_pkg::OFS_RXB ||
                araddr == i2cms_pkg::OFS_IMASK || araddr == i2cms_pkg::OFS_ISTAT;
  // Sequencer timing strobes.
  wire busy = state != i2cms_pkg::S_IDLE;
  wire tick = busy && qcnt == 16'(QUARTER - 1); // End of a quarter.
  wire slot_end = tick && q == 2'd3; // End of a bit slot.
  wire sample = tick && q == 2'd2; // Clock high, data settled.
  wire single = state == i2cms_pkg::S_START || state == i2cms_pkg::S_RESTART ||
                state == i2cms_pkg::S_STOP || state == i2cms_pkg::S_ACK;
  wire done = slot_end && (single || (state == i2cms_pkg::S_XMIT && bitcnt == 4'd8) ||
              (state == i2cms_pkg::S_RECV && bitcnt == 4'd7));
  wire rx_done = done && state == i2cms_pkg::S_RECV;
  wire ack_slot = sample && state == i2cms_pkg::S_XMIT && bitcnt == 4'd8;
  // A line we release but find low means another master won the bus.
  wire chk_start = tick && ((state == i2cms_pkg::S_START && q == 2'd0) ||
                   (state == i2cms_pkg::S_RESTART && q == 2'd1)); // Both lines released.
  wire chk_data = sample && serial_data_pin_oe_n &&
                  ((state == i2cms_pkg::S_XMIT && bitcnt != 4'd8) ||
                   state == i2cms_pkg::S_ACK);
  wire coll = (chk_start && !(sda_s2 && scl_s2)) || (chk_data && !sda_s2); // [R11]
  // Request bits that hardware clears this cycle.
  wire [4:0] hw_clr = coll ? 5'h1f : {
    done && state == i2cms_pkg::S_ACK, // [R4]
    rx_done, // [R5]
    done && state == i2cms_pkg::S_STOP, // [R6]
    done && state == i2cms_pkg::S_RESTART, // [R7]
    done && state == i2cms_pkg::S_START}; // [R9]
  wire [4:0] req = ctrl[4:0]; // Pending requests.
  ////////////////////////////////////////////////////////////////////////////////
  // Pin drive table: one means the line is released.
  always_comb
  begin
    next_sda_rel = 1'b1;
    next_scl_rel = !hold_low;
    case (state)
      i2cms_pkg::S_START:
      begin
        next_sda_rel = q == 2'd0; // Data falls with clock high. [R8]
        next_scl_rel = q != 2'd3;
      end
      i2cms_pkg::S_RESTART:
      begin
        next_sda_rel = q <= 2'd1; // Data falls with clock high. [R7]
        next_scl_rel = q == 2'd1 || q == 2'd2;
      end
      i2cms_pkg::S_STOP:
      begin
        next_sda_rel = q >= 2'd2; // Data rises with clock high. [R6]
        next_scl_rel = q >= 2'd1;
      end
      i2cms_pkg::S_XMIT:
      begin
        next_sda_rel = bitcnt == 4'd8 ? 1'b1 : txsh[7];
        next_scl_rel = q[1];
      end
      i2cms_pkg::S_RECV: next_scl_rel = q[1];
      i2cms_pkg::S_ACK:
      begin
        next_sda_rel = ctrl.ack_value_select; // One releases for NACK. [R1] [R2]
        next_scl_rel = q[1];
      end
      default: next_sda_rel = 1'b1;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and registered pin drive.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {sda_s1, sda_s2, scl_s1, scl_s2} <= 4'hf;
      serial_data_pin_oe_n <= 1'b1;
      serial_clock_pin_oe_n <= 1'b1;
    end
    else
    begin
      {sda_s2, sda_s1} <= {sda_s1, serial_data_pin_in};
      {scl_s2, scl_s1} <= {scl_s1, serial_clock_pin_in};
      serial_data_pin_oe_n <= next_sda_rel;
      serial_clock_pin_oe_n <= next_scl_rel;
    end
  end
  assign serial_data_pin_out = 1'b0;
  assign serial_clock_pin_out = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: picks one request when idle, walks the quarters.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || coll)
    begin
      state <= i2cms_pkg::S_IDLE;
      qcnt <= 16'h0000;
      q <= 2'd0;
      bitcnt <= 4'h0;
    end
    else if (!busy)
    begin
      qcnt <= 16'h0000;
      q <= 2'd0;
      bitcnt <= 4'h0;
      if (ctrl.enable)
      begin
        if (ctrl.start_request)
          state <= i2cms_pkg::S_START; // [R8]
        else if (ctrl.restart_request)
          state <= i2cms_pkg::S_RESTART; // [R7]
        else if (ctrl.stop_request)
          state <= i2cms_pkg::S_STOP; // [R6]
        else if (ctrl.receive_byte_request)
          state <= i2cms_pkg::S_RECV; // [R5]
        else if (ctrl.ack_sequence_request)
          state <= i2cms_pkg::S_ACK; // [R3]
        else if (transmit_buffer_full)
          state <= i2cms_pkg::S_XMIT;
      end
    end
    else
    begin
      qcnt <= tick ? 16'h0000 : qcnt + 16'h0001;
      if (tick)
        q <= q + 2'd1;
      if (slot_end)
        bitcnt <= bitcnt + 4'h1;
      if (done)
        state <= i2cms_pkg::S_IDLE;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Data path: shifters, buffers and bus holding.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      txsh <= 8'h00;
      rxsh <= 8'h00;
      transmit_buffer <= 8'h00;
      receive_buffer <= 8'h00;
      transmit_buffer_full <= 1'b0;
      receive_buffer_full <= 1'b0;
      slave_ack_flag <= 1'b0;
      hold_low <= 1'b0;
    end
    else
    begin
      if (wr_txb && !transmit_buffer_full)
      begin
        transmit_buffer <= wdata[7:0];
        txsh <= wdata[7:0];
        transmit_buffer_full <= 1'b1;
      end
      else if (state == i2cms_pkg::S_XMIT && (done || coll))
        transmit_buffer_full <= 1'b0;
      else if (state == i2cms_pkg::S_XMIT && slot_end)
        txsh <= {txsh[6:0], 1'b0};
      if (sample && state == i2cms_pkg::S_RECV)
        rxsh <= {rxsh[6:0], sda_s2};
      if (rx_done)
        receive_buffer <= rxsh; // Last bit was shifted in at the sample.
      if (rx_done)
        receive_buffer_full <= 1'b1; // Set wins over a read. [R10]
      else if (rd_rxb)
        receive_buffer_full <= 1'b0; // [R10]
      if (ack_slot)
        slave_ack_flag <= sda_s2; // [R12]
      hold_low <= !coll && (done ? state != i2cms_pkg::S_STOP : hold_low); // Held until Stop or a collision.
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Control, collision and interrupt registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= i2cms_pkg::CTRL_RESET;
      bus_collision_flag <= 1'b0;
      irq_stat <= i2cms_pkg::IRQ_RESET;
      irq_mask <= i2cms_pkg::IRQ_RESET;
    end
    else
    begin
      // Software sets requests; a write in the clearing cycle wins. [R3]
      ctrl <= wr_ctrl ? ((ctrl & ~wmask) | (wd & wmask) | {11'h000, req & ~hw_clr})
                      : (ctrl & ~{11'h000, hw_clr});
      bus_collision_flag <= coll || (bus_collision_flag &&
                            !(wr_stat && wd[i2cms_pkg::ST_BCL_BIT])); // [R11]
      irq_stat <= {coll, rx_done, done} |
                  (irq_stat & ~(wr_istat ? wd[2:0] : 3'h0));
      if (wr_imask)
        irq_mask <= wd[2:0];
    end
  end
  assign irq = |(irq_stat & irq_mask);
  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: one write and one read at a time.
  assign awready = wr_go;
  assign wready = wr_go;
  assign arready = rd_go;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (araddr)
      i2cms_pkg::OFS_CTRL: rd_mux[15:0] = ctrl;
      i2cms_pkg::OFS_STAT:
      begin
        rd_mux[i2cms_pkg::ST_ACK_BIT] = slave_ack_flag;
        rd_mux[i2cms_pkg::ST_BUSY_BIT] = state == i2cms_pkg::S_XMIT;
        rd_mux[i2cms_pkg::ST_BCL_BIT] = bus_collision_flag;
        rd_mux[i2cms_pkg::ST_RBF_BIT] = receive_buffer_full;
        rd_mux[i2cms_pkg::ST_TBF_BIT] = transmit_buffer_full;
      end
      i2cms_pkg::OFS_TXB: rd_mux[7:0] = transmit_buffer;
      i2cms_pkg::OFS_RXB: rd_mux[7:0] = receive_buffer;
      i2cms_pkg::OFS_IMASK: rd_mux[2:0] = irq_mask;
      i2cms_pkg::OFS_ISTAT: rd_mux[2:0] = irq_stat;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  // Response channels stand until the master takes them.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= i2cms_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= i2cms_pkg::RESP_OKAY;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      if (wr_go)
      begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? i2cms_pkg::RESP_OKAY : i2cms_pkg::RESP_SLVERR;
      end
      else if (bready)
        bvalid <= 1'b0;
      if (rd_go)
      begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_hit ? i2cms_pkg::RESP_OKAY : i2cms_pkg::RESP_SLVERR;
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  AST_ACK_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    state == i2cms_pkg::S_ACK |=> serial_data_pin_oe_n == $past(ctrl.ack_value_select))
    else $error("Acknowledge slot drives wrong value.");
  AST_ACK_NACK: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    state == i2cms_pkg::S_ACK && !ctrl.ack_value_select |=> !serial_data_pin_oe_n)
    else $error("ACK not driven low.");
  AST_ACK_LAUNCH: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    !busy && ctrl.enable && req == 5'h10 && !coll |=> state == i2cms_pkg::S_ACK)
    else $error("Acknowledge request not launched.");
  AST_ACK_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    $fell(ctrl.ack_sequence_request) |-> $past(state) == i2cms_pkg::S_ACK)
    else $error("Acknowledge request cleared outside its sequence.");
  AST_RECV_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
    $past(rx_done) |-> !ctrl.receive_byte_request || $past(wr_ctrl))
    else $error("Receive request not cleared after byte.");
  AST_STOP_END: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    done && state == i2cms_pkg::S_STOP && !wr_ctrl |=> !ctrl.stop_request ##0
    serial_data_pin_oe_n && serial_clock_pin_oe_n)
    else $error("Stop sequence did not end released.");
  AST_RESTART_END: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    done && state == i2cms_pkg::S_RESTART && !wr_ctrl |=> !ctrl.restart_request)
    else $error("Restart request not cleared.");
  AST_START_SDA: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    state == i2cms_pkg::S_START && q == 2'd1 |=> !serial_data_pin_oe_n &&
    serial_clock_pin_oe_n)
    else $error("Start does not pull data low with clock high.");
  AST_START_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
    done && state == i2cms_pkg::S_START && !wr_ctrl |=> !ctrl.start_request)
    else $error("Start request not cleared.");
  AST_RBF: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    $rose(receive_buffer_full) |-> $past(rx_done))
    else $error("Receive full set without a byte.");
  AST_BCL: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    $fell(bus_collision_flag) |-> $past(wr_stat) && !$past(coll))
    else $error("Collision flag cleared without software.");
  AST_SLAVE_ACK_FLAG: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
    $changed(slave_ack_flag) |-> $past(ack_slot))
    else $error("Acknowledge status changed outside the slot.");
  COV_START: cover property (@(posedge aclk) done && state == i2cms_pkg::S_START);
  COV_RECV: cover property (@(posedge aclk) rx_done);
  COV_XMIT: cover property (@(posedge aclk) ack_slot);
  COV_COLL: cover property (@(posedge aclk) coll);
endmodule // i2cms_core

/* logic/i2cms_pkg.sv */
// Purpose: Shared constants and types of the two-wire master sequencer.
// Assumes: 25 MHz aclk, AXI4-Lite register access, 32-bit data.
// Notes: Registers are 16 bits wide in the low half of each word.
package i2cms_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_TXB = 8'h08;
  localparam logic [7:0] OFS_RXB = 8'h0c;
  localparam logic [7:0] OFS_IMASK = 8'h10;
  localparam logic [7:0] OFS_ISTAT = 8'h14;
  // Status register bit positions.
  localparam int ST_ACK_BIT = 15;
  localparam int ST_BUSY_BIT = 14;
  localparam int ST_BCL_BIT = 10;
  localparam int ST_RBF_BIT = 1;
  localparam int ST_TBF_BIT = 0;
  // Interrupt bit positions: sequence done, byte received, collision.
  localparam int IRQ_DONE = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_BCL = 2;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  // Bus timing: one bit period, split in four quarters.
  localparam int CLK_NS = 40;
  localparam int BIT_NS = 10000;
  localparam int QUARTER_CYCLES = (BIT_NS / 4 + CLK_NS - 1) / CLK_NS;
  // Response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Control register layout.
  typedef struct packed {
    logic enable;
    logic [8:0] rsvd;
    logic ack_value_select;
    logic ack_sequence_request;
    logic receive_byte_request;
    logic stop_request;
    logic restart_request;
    logic start_request;
  } i2cms_ctrl_t;
  // Sequencer states.
  typedef enum logic [2:0] {
    S_IDLE, S_START, S_RESTART, S_STOP, S_XMIT, S_RECV, S_ACK
  } i2cms_state_t;
endpackage

/* tb/i2cms_slave_model.sv */
// Purpose: Behavioural slave on the two-wire bus for the sequencer bench.
// Assumes: Open-drain lines with pull-ups; the bench resolves the levels.
// Notes: Counts nine-slot frames from each Start; misbehaves only on hold_low.
module i2cms_slave_model (
  input wire logic scl, // Resolved clock line.
  input wire logic sda, // Resolved data line.
  input wire logic read_mode, // High: slave sends tx_byte in slots 0 to 7.
  input wire logic ack_en, // High: slave acknowledges written bytes.
  input wire logic hold_low, // High: data held low to force a collision.
  input wire logic [7:0] tx_byte, // Byte sent while in read mode.
  output logic sda_n, // Low while the model pulls data low.
  output logic [7:0] rx_byte, // Last eight data bits seen on the line.
  output logic ack_seen // Data level in the last acknowledge slot.
);
  timeunit 1ns;
  timeprecision 1ps;
  int slot = -1; // Slot being set up; -1 until the first after a Start.
  logic quiet = 1'b0; // Set once a frame ends without a read acknowledge.
  logic drive = 1'b0; // Data pull wanted in the current slot.
  // A Start restarts the count; the delay lets a same-step clock fall land.
  always @(negedge sda)
    #1 if (scl === 1'b1)
    begin
      slot = -1;
      quiet = 1'b0;
    end
  // Data changes only while the clock is low, as a real slave does.
  always @(negedge scl)
  begin
    slot = (slot + 1) % 9;
    if (read_mode)
      drive = (slot < 8) && !quiet && !tx_byte[7 - slot];
    else
      drive = (slot == 8) && ack_en;
  end
  // Rising clock samples data; a NACK or a written frame silences the model.
  always @(posedge scl)
    if (slot == 8)
    begin
      ack_seen = sda;
      quiet = !(read_mode && !sda);
    end
    else if (slot >= 0)
      rx_byte = {rx_byte[6:0], sda};
  assign sda_n = !(drive || hold_low);
endmodule // i2cms_slave_model

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the two-wire master sequencer.
// Assumes: QUARTER set to 4, so one bit slot lasts 16 aclk cycles.
// Notes: Registers reached by AXI4-Lite tasks; a slave model answers the wire.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0; // System clock, 40 ns period.
  logic aresetn = 1'b0; // Synchronous reset, active low.
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0; // Write channel.
  logic arvalid = 1'b0, rready = 1'b0; // Read channel.
  logic [7:0] awaddr = 8'h00, araddr = 8'h00; // Register addresses.
  logic [31:0] wdata = 32'h0; // Write data.
  logic awready, wready, bvalid, arready, rvalid, irq; // Design answers.
  logic [1:0] bresp, rresp, rr; // Response codes and the last one seen.
  logic [31:0] rdata, rv; // Read data and the last value read.
  logic sda_out, sda_oe_n, scl_out, scl_oe_n; // Pin drives.
  logic rd_mode = 1'b0, ack_en = 1'b1, hold = 1'b0; // Slave behaviour.
  logic [7:0] tx = 8'h00; // Byte the slave sends.
  logic slv_n, ack_seen; // Slave pull and sampled acknowledge.
  logic [7:0] rx; // Byte the slave received.
  logic sda_q = 1'b1, scl_q = 1'b1; // Line levels one cycle ago.
  int fail_count = 0, checks = 0, n_start = 0, n_stop = 0;
  // Pull-ups make a released line high.
  wire sda = (sda_oe_n ? 1'b1 : sda_out) & slv_n;
  wire scl = scl_oe_n ? 1'b1 : scl_out;
  always #20 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  i2cms_core #(.QUARTER(4)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .serial_data_pin_in(sda),
    .serial_data_pin_out(sda_out), .serial_data_pin_oe_n(sda_oe_n),
    .serial_clock_pin_in(scl), .serial_clock_pin_out(scl_out),
    .serial_clock_pin_oe_n(scl_oe_n), .irq(irq)
  );
  i2cms_slave_model slave (
    .scl(scl), .sda(sda), .read_mode(rd_mode), .ack_en(ack_en),
    .hold_low(hold), .tx_byte(tx), .sda_n(slv_n), .rx_byte(rx),
    .ack_seen(ack_seen)
  );
  // Start and Stop conditions on the wire, sampled so that a joint fall is neither.
  always @(posedge aclk)
  begin
    if (scl && scl_q && sda_q && !sda) n_start <= n_start + 1;
    if (scl && scl_q && !sda_q && sda) n_stop <= n_stop + 1;
    sda_q <= sda;
    scl_q <= scl;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Counts one step of a wait and ends the run when the wait hangs.
  task automatic tick(inout int n);
    n++;
    if (n > 400)
    begin
      fail_count++;
      final_report();
    end
  endtask
  // One write; the extra edge keeps bready from being set twice in a step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      tick(n);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    rr = bresp;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      tick(n);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    rv = rdata;
    rr = rresp;
    @(posedge aclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    check(rv & m, e);
  endtask
  // Launches sequences through the control word, waits for self-clearing and a sent byte.
  task automatic seq(input logic [31:0] bits);
    int n;
    n = 0;
    wr(i2cms_pkg::OFS_CTRL, 32'h8000 | bits);
    do
    begin
      rd(i2cms_pkg::OFS_CTRL);
      tick(n);
    end
    while ((rv & 32'h1f) !== 32'h0);
    do
    begin
      rd(i2cms_pkg::OFS_STAT);
      tick(n);
    end
    while (rv[0] !== 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] b;
    logic a;
    int es, ep;
    es = 0;
    ep = 0;
    void'($urandom(32'hdab3));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset state, then an unmapped address.
    rdchk(i2cms_pkg::OFS_CTRL, 32'hffff, 32'h0);
    rdchk(i2cms_pkg::OFS_STAT, 32'hffff, 32'h0);
    rdchk(i2cms_pkg::OFS_ISTAT, 32'h7, 32'h0);
    rd(8'h20);
    check(rr, i2cms_pkg::RESP_SLVERR);
    check(irq, 1'b0);
    wr(i2cms_pkg::OFS_IMASK, 32'h2);
    check(rr, i2cms_pkg::RESP_OKAY);
    wr(8'h20, 32'h0);
    check(rr, i2cms_pkg::RESP_SLVERR);
    // Random frames: start, write, restart, two reads, stop.
    for (int i = 0; i < 3; i++)
    begin
      b = 8'($urandom);
      a = 1'($urandom);
      ack_en <= a;
      rd_mode <= 1'b0;
      seq(32'h1);
      check(n_start, ++es);
      rdchk(i2cms_pkg::OFS_ISTAT, 32'h1, 32'h1);
      check(irq, 1'b0);
      wr(i2cms_pkg::OFS_TXB, {24'h0, b});
      rdchk(i2cms_pkg::OFS_STAT, 32'h4001, 32'h4001);
      seq(32'h0);
      rdchk(i2cms_pkg::OFS_STAT, 32'h4001, 32'h0);
      check(rx, b);
      rdchk(i2cms_pkg::OFS_STAT, 32'h8000, a ? 32'h0 : 32'h8000);
      rd_mode <= 1'b1;
      tx <= 8'($urandom);
      seq(32'h2);
      check(n_start, ++es);
      for (int k = 0; k < 2; k++)
      begin
        seq(32'h8);
        rdchk(i2cms_pkg::OFS_STAT, 32'h2, 32'h2);
        check(irq, 1'b1);
        rdchk(i2cms_pkg::OFS_RXB, 32'hff, {24'h0, tx});
        rdchk(i2cms_pkg::OFS_STAT, 32'h2, 32'h0);
        wr(i2cms_pkg::OFS_ISTAT, 32'h7);
        check(irq, 1'b0);
        tx <= 8'($urandom);
        seq(32'h10 | (k << 5));
        check(ack_seen, k);
      end
      seq(32'h4);
      check(n_stop, ++ep);
    end
    // A slave holding data low makes the Start collide.
    wr(i2cms_pkg::OFS_IMASK, 32'h4);
    hold <= 1'b1;
    seq(32'h1);
    hold <= 1'b0;
    rdchk(i2cms_pkg::OFS_STAT, 32'h400, 32'h400);
    check(irq, 1'b1);
    wr(i2cms_pkg::OFS_STAT, 32'h400);
    rdchk(i2cms_pkg::OFS_STAT, 32'h400, 32'h0);
    wr(i2cms_pkg::OFS_ISTAT, 32'h4);
    check(irq, 1'b0);
    final_report();
  end
endmodule // tb_top
